// ===== rsaq_radio_seq.sv
// radio state sequencer with auto-ack, energy detect and i/q mode control
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module rsaq_radio_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic preamble_det,
  input wire logic header_ok,
  input wire logic addr_match,
  input wire logic frame_done,
  input wire logic frame_abort,
  input wire logic fcs_ok,
  input wire logic ack_required,
  input wire logic [7:0] energy_sample,
  input wire logic iq_tx_start_flag,
  input wire logic iq_sample_clk,
  output logic agc_freeze,
  output logic ack_tx_start,
  input wire logic tx_done,
  output logic tx_active,
  output logic iq_out_enable,
  output logic iq_serial_out_clock,
  output logic iq_rx_stream,
  output logic [rsaq_pkg::RSAQ_IRQ_W-1:0] irq_status
);
  import rsaq_pkg::*;

  rsaq_state_t state_r;
  logic [7:0] ctrl_r;
  logic [7:0] ack_delay_low_r;
  logic [7:0] ack_delay_high_r;
  logic [7:0] energy_detect_duration_r;
  logic [7:0] energy_value_r;
  logic [RSAQ_IRQ_W-1:0] irq_r;
  logic [RSAQ_IRQ_W-1:0] irq_set;
  logic [15:0] tmr_r;
  logic [7:0] unit_r;
  logic agc_hold_r;
  logic [7:0] ed_cnt_r;
  logic [7:0] ed_unit_r;
  logic ed_run_r;
  logic [7:0] ed_max_r;
  logic gain_freeze_control_q_r;
  logic [1:0] flag_sync_r;
  logic [1:0] clk_sync_r;
  logic flag_prev_r;
  logic [2:0] iq_div_r;
  logic iq_clk_r;
  logic ack_start_r;

  logic wr_en;
  logic rd_en;
  logic cmd_wr;
  logic [2:0] cmd_val;
  logic eec;
  logic iq_mode;
  logic flag_rise;
  logic flag_fall;
  logic edm_wr;

  // reads are single wait-free; pready tied high keeps the slave zero wait
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  assign cmd_wr = wr_en && (paddr == RSAQ_ADDR_CMD);
  assign cmd_val = pwdata[2:0];
  assign eec = ctrl_r[RSAQ_CTRL_EEC];
  assign iq_mode = ctrl_r[RSAQ_CTRL_CHIP_MODE_FIELD_LO +: 2] == RSAQ_CHIP_MODE_FIELD_IQ;
  assign edm_wr = wr_en && (paddr == RSAQ_ADDR_CTRL);

  // start flag and sample clock come from the baseband domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_sync_r <= 2'b00;
      clk_sync_r <= 2'b00;
      flag_prev_r <= 1'b0;
    end else begin
      flag_sync_r <= {flag_sync_r[0], iq_tx_start_flag};
      clk_sync_r <= {clk_sync_r[0], iq_sample_clk};
      if (clk_sync_r[1] & ~flag_prev_r | clk_sync_r[1] & flag_prev_r | ~clk_sync_r[1])
        flag_prev_r <= flag_sync_r[1];
    end
  end
  assign flag_rise = flag_sync_r[1] & ~flag_prev_r;
  assign flag_fall = ~flag_sync_r[1] & flag_prev_r;

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= {RSAQ_EDM_OFF, 6'h00};
      ack_delay_low_r <= 8'h00;
      ack_delay_high_r <= 8'h00;
      energy_detect_duration_r <= RSAQ_EDD_RESET;
    end else if (wr_en) begin
      case (paddr)
        RSAQ_ADDR_CTRL: ctrl_r <= pwdata[7:0];
        RSAQ_ADDR_ACKL: ack_delay_low_r <= pwdata[7:0];
        RSAQ_ADDR_ACKH: ack_delay_high_r <= pwdata[7:0];
        RSAQ_ADDR_EDD: energy_detect_duration_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (paddr)
      RSAQ_ADDR_CTRL: prdata = {24'h000000, ctrl_r};
      RSAQ_ADDR_ACKL: prdata = {24'h000000, ack_delay_low_r};
      RSAQ_ADDR_ACKH: prdata = {24'h000000, ack_delay_high_r};
      RSAQ_ADDR_EDD: prdata = {24'h000000, energy_detect_duration_r};
      RSAQ_ADDR_STAT: prdata = {29'h00000000, state_r};
      RSAQ_ADDR_IRQ: prdata = {26'h0000000, irq_r};
      RSAQ_ADDR_EDV: prdata = {24'h000000, energy_value_r};
      default: prdata = 32'h00000000;
    endcase
  end

  // state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= RSAQ_ST_OFF;
      tmr_r <= 16'h0000;
      unit_r <= 8'h00;
      ack_start_r <= 1'b0;
    end else begin
      ack_start_r <= 1'b0;
      case (state_r)
        RSAQ_ST_OFF: begin
          if (cmd_wr && cmd_val == RSAQ_CMD_TRANSMIT_PREPARE_STATE)
            state_r <= RSAQ_ST_TRANSMIT_PREPARE_STATE;
        end
        RSAQ_ST_TRANSMIT_PREPARE_STATE: begin
          if (eec && iq_mode && flag_rise)
            state_r <= RSAQ_ST_TX;
          else if (cmd_wr && cmd_val == RSAQ_CMD_RX)
            state_r <= RSAQ_ST_RX;
          else if (cmd_wr && cmd_val == RSAQ_CMD_TX && !eec)
            state_r <= RSAQ_ST_TX;
          else if (cmd_wr && cmd_val == RSAQ_CMD_OFF)
            state_r <= RSAQ_ST_OFF;
        end
        RSAQ_ST_RX: begin
          if (cmd_wr && cmd_val == RSAQ_CMD_TRANSMIT_PREPARE_STATE)
            state_r <= RSAQ_ST_TRANSMIT_PREPARE_STATE;
          else if (!iq_mode && frame_done && fcs_ok && !frame_abort) begin
            if (ctrl_r[RSAQ_CTRL_AUTO_ACK_FUNCTION] && ack_required) begin
              state_r <= RSAQ_ST_ACKWAIT;
              tmr_r <= {ack_delay_high_r, ack_delay_low_r};
              unit_r <= RSAQ_ACK_UNIT_CYC;
            end else
              state_r <= RSAQ_ST_TRANSMIT_PREPARE_STATE;
          end
        end
        RSAQ_ST_ACKWAIT: begin
          // frame-end with auto-ack and ack required comes here instead of prepare; the timer runs here
          if (tmr_r == 16'h0000) begin
            state_r <= RSAQ_ST_TX;
            ack_start_r <= 1'b1;
          end else if (unit_r <= 8'h01) begin
            unit_r <= RSAQ_ACK_UNIT_CYC;
            tmr_r <= tmr_r - 16'h0001;
          end else
            unit_r <= unit_r - 8'h01;
        end
        RSAQ_ST_TX: begin
          if (iq_mode && eec && flag_fall) begin
            state_r <= RSAQ_ST_RAMPDN;
            tmr_r <= RSAQ_RAMP_CYC;
          end else if (iq_mode && !eec && cmd_wr && cmd_val == RSAQ_CMD_TRANSMIT_PREPARE_STATE)
            state_r <= RSAQ_ST_TRANSMIT_PREPARE_STATE;
          else if (!iq_mode && tx_done)
            state_r <= RSAQ_ST_TRANSMIT_PREPARE_STATE;
        end
        RSAQ_ST_RAMPDN: begin
          if (tmr_r <= 16'h0001)
            state_r <= RSAQ_ST_TRANSMIT_PREPARE_STATE;
          else
            tmr_r <= tmr_r - 16'h0001;
        end
        default: state_r <= RSAQ_ST_OFF;
      endcase
    end
  end

  // irq events
  always_comb begin
    irq_set = '0;
    irq_set[RSAQ_IRQ_FRAME_START_IRQ] = state_r == RSAQ_ST_RX && header_ok;
    irq_set[RSAQ_IRQ_ADDRESS_MATCH_IRQ] = state_r == RSAQ_ST_RX && addr_match;
    irq_set[RSAQ_IRQ_FRAME_END_IRQ] = state_r == RSAQ_ST_RX && !iq_mode && frame_done && fcs_ok
      && !frame_abort;
    irq_set[RSAQ_IRQ_TRANSMIT_FRAME_END_IRQ] = state_r == RSAQ_ST_TX && !iq_mode && tx_done;
    irq_set[RSAQ_IRQ_EDC] = ed_run_r && ed_cnt_r == 8'h00 && ed_unit_r <= 8'h01;
    irq_set[RSAQ_IRQ_TRANSCEIVER_READY_IRQ] = 1'b0;
  end

  logic prev_prep_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prev_prep_r <= 1'b0;
    else
      prev_prep_r <= state_r == RSAQ_ST_TRANSMIT_PREPARE_STATE;
  end

  // read of irq clears it; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_r <= '0;
    else begin
      irq_r <= ((psel && penable && rd_en && paddr == RSAQ_ADDR_IRQ) ? '0 : irq_r) | irq_set;
      if (state_r == RSAQ_ST_TRANSMIT_PREPARE_STATE && !prev_prep_r)
        irq_r[RSAQ_IRQ_TRANSCEIVER_READY_IRQ] <= 1'b1;
    end
  end
  assign irq_status = irq_r;

  // agc hold follows preamble until the frame ends or is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      agc_hold_r <= 1'b0;
    else if (state_r != RSAQ_ST_RX || frame_abort || (frame_done && !fcs_ok))
      agc_hold_r <= 1'b0;
    else if (preamble_det)
      agc_hold_r <= 1'b1;
  end
  assign agc_freeze = agc_hold_r | ctrl_r[RSAQ_CTRL_GAIN_FREEZE_CONTROL];

  // energy detect timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ed_run_r <= 1'b0;
      ed_cnt_r <= 8'h00;
      ed_unit_r <= 8'h00;
      ed_max_r <= 8'h00;
      energy_value_r <= 8'h00;
      gain_freeze_control_q_r <= 1'b0;
    end else begin
      gain_freeze_control_q_r <= ctrl_r[RSAQ_CTRL_GAIN_FREEZE_CONTROL];
      if (edm_wr && (pwdata[RSAQ_CTRL_EDM_LO +: 2] == RSAQ_EDM_SINGLE
          || pwdata[RSAQ_CTRL_EDM_LO +: 2] == RSAQ_EDM_CONT)) begin
        ed_run_r <= 1'b1;
        ed_cnt_r <= energy_detect_duration_r;
        ed_unit_r <= RSAQ_ED_UNIT_CYC;
        ed_max_r <= 8'h00;
      end else if (ctrl_r[RSAQ_CTRL_EDM_LO +: 2] == RSAQ_EDM_AUTO
          && ctrl_r[RSAQ_CTRL_GAIN_FREEZE_CONTROL] && !gain_freeze_control_q_r) begin
        ed_run_r <= 1'b1;
        ed_cnt_r <= energy_detect_duration_r;
        ed_unit_r <= RSAQ_ED_UNIT_CYC;
        ed_max_r <= 8'h00;
      end else if (ed_run_r) begin
        if (energy_sample > ed_max_r)
          ed_max_r <= energy_sample;
        if (ed_unit_r > 8'h01)
          ed_unit_r <= ed_unit_r - 8'h01;
        else if (ed_cnt_r != 8'h00) begin
          ed_unit_r <= RSAQ_ED_UNIT_CYC;
          ed_cnt_r <= ed_cnt_r - 8'h01;
        end else begin
          energy_value_r <= ed_max_r;
          ed_max_r <= 8'h00;
          if (ctrl_r[RSAQ_CTRL_EDM_LO +: 2] == RSAQ_EDM_CONT) begin
            ed_cnt_r <= energy_detect_duration_r;
            ed_unit_r <= RSAQ_ED_UNIT_CYC;
          end else
            ed_run_r <= 1'b0;
        end
      end
    end
  end

  // serial i/q output clock divider, active from transmit-prepare onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iq_div_r <= 3'h0;
      iq_clk_r <= 1'b0;
    end else if (iq_out_enable) begin
      iq_div_r <= iq_div_r + 3'h1;
      // low two bits wrap every four cycles, giving pclk/8
      if (iq_div_r[1:0] == 2'h3)
        iq_clk_r <= ~iq_clk_r;
    end else begin
      iq_div_r <= 3'h0;
      iq_clk_r <= 1'b0;
    end
  end

  assign iq_out_enable = iq_mode && state_r != RSAQ_ST_OFF;
  assign iq_serial_out_clock = iq_clk_r;
  assign iq_rx_stream = iq_mode && state_r == RSAQ_ST_RX;
  assign tx_active = state_r == RSAQ_ST_TX || state_r == RSAQ_ST_RAMPDN;
  assign ack_tx_start = ack_start_r;

  property p_ackgap;
    @(posedge pclk) disable iff (!presetn)
    ack_start_r |-> $past(state_r) == RSAQ_ST_ACKWAIT && state_r == RSAQ_ST_TX;
  endproperty
  a_ackgap: assert property (p_ackgap) else $error("ack start without wait");
  property p_rdy;
    @(posedge pclk) disable iff (!presetn)
    (state_r == RSAQ_ST_TRANSMIT_PREPARE_STATE && !prev_prep_r) |=> irq_r[RSAQ_IRQ_TRANSCEIVER_READY_IRQ];
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready irq missing");
  property p_off;
    @(posedge pclk) disable iff (!presetn)
    (state_r == RSAQ_ST_OFF && !(cmd_wr && cmd_val == RSAQ_CMD_TRANSMIT_PREPARE_STATE)) |=>
    state_r == RSAQ_ST_OFF;
  endproperty
  a_off: assert property (p_off) else $error("off left without command");
  property p_eec;
    @(posedge pclk) disable iff (!presetn)
    (state_r == RSAQ_ST_TRANSMIT_PREPARE_STATE && eec && cmd_wr && cmd_val == RSAQ_CMD_TX && !flag_rise)
    |=> state_r != RSAQ_ST_TX;
  endproperty
  a_eec: assert property (p_eec) else $error("tx cmd not ignored");
  property p_fe;
    @(posedge pclk) disable iff (!presetn)
    (state_r == RSAQ_ST_RX && frame_done && !fcs_ok && !cmd_wr) |=>
    state_r == RSAQ_ST_RX && !agc_hold_r;
  endproperty
  a_fe: assert property (p_fe) else $error("bad frame left rx");
  property p_agc;
    @(posedge pclk) disable iff (!presetn)
    (state_r == RSAQ_ST_RX && preamble_det && !frame_abort && !frame_done && !cmd_wr)
    |=> agc_freeze;
  endproperty
  a_agc: assert property (p_agc) else $error("agc not held");
  property p_frame_end_irq;
    @(posedge pclk) disable iff (!presetn)
    $rose(irq_r[RSAQ_IRQ_FRAME_END_IRQ]) |-> $past(fcs_ok);
  endproperty
  a_frame_end_irq: assert property (p_frame_end_irq) else $error("frame_end_irq on bad fcs");
  property p_ramp;
    @(posedge pclk) disable iff (!presetn)
    $rose(state_r == RSAQ_ST_RAMPDN) |-> ##[1:300] state_r == RSAQ_ST_TRANSMIT_PREPARE_STATE;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp down stuck");
endmodule // rsaq_radio_seq

// ===== rsaq_pkg.sv
// package of constants and types for the radio state sequencer
package rsaq_pkg;
  localparam logic [11:0] RSAQ_ADDR_CMD = 12'h000;
  localparam logic [11:0] RSAQ_ADDR_CTRL = 12'h004;
  localparam logic [11:0] RSAQ_ADDR_ACKL = 12'h008;
  localparam logic [11:0] RSAQ_ADDR_ACKH = 12'h00C;
  localparam logic [11:0] RSAQ_ADDR_EDD = 12'h010;
  localparam logic [11:0] RSAQ_ADDR_STAT = 12'h014;
  localparam logic [11:0] RSAQ_ADDR_IRQ = 12'h018;
  localparam logic [11:0] RSAQ_ADDR_EDV = 12'h01C;
  localparam logic [2:0] RSAQ_CMD_NOP = 3'h0;
  localparam logic [2:0] RSAQ_CMD_OFF = 3'h2;
  localparam logic [2:0] RSAQ_CMD_TRANSMIT_PREPARE_STATE = 3'h3;
  localparam logic [2:0] RSAQ_CMD_TX = 3'h4;
  localparam logic [2:0] RSAQ_CMD_RX = 3'h5;
  // control register fields
  localparam int RSAQ_CTRL_AUTO_ACK_FUNCTION = 0;
  localparam int RSAQ_CTRL_EEC = 1;
  localparam int RSAQ_CTRL_GAIN_FREEZE_CONTROL = 2;
  localparam int RSAQ_CTRL_CHIP_MODE_FIELD_LO = 4;
  localparam int RSAQ_CTRL_EDM_LO = 6;
  localparam logic [1:0] RSAQ_CHIP_MODE_FIELD_IQ = 2'h1;
  localparam logic [1:0] RSAQ_EDM_AUTO = 2'h0;
  localparam logic [1:0] RSAQ_EDM_SINGLE = 2'h1;
  localparam logic [1:0] RSAQ_EDM_CONT = 2'h2;
  localparam logic [1:0] RSAQ_EDM_OFF = 2'h3;
  localparam logic [7:0] RSAQ_EDD_RESET = 8'h10;
  // irq bit positions
  localparam int RSAQ_IRQ_FRAME_START_IRQ = 0;
  localparam int RSAQ_IRQ_FRAME_END_IRQ = 1;
  localparam int RSAQ_IRQ_ADDRESS_MATCH_IRQ = 2;
  localparam int RSAQ_IRQ_TRANSMIT_FRAME_END_IRQ = 3;
  localparam int RSAQ_IRQ_TRANSCEIVER_READY_IRQ = 4;
  localparam int RSAQ_IRQ_EDC = 5;
  localparam int RSAQ_IRQ_W = 6;
  // ack delay counts in clock cycles per unit
  localparam int RSAQ_CLK_MHZ = 50;
  localparam int RSAQ_ACK_UNIT_US = 1;
  localparam logic [7:0] RSAQ_ACK_UNIT_CYC = 8'(RSAQ_CLK_MHZ * RSAQ_ACK_UNIT_US);
  localparam int RSAQ_ED_UNIT_US = 2;
  localparam logic [7:0] RSAQ_ED_UNIT_CYC = 8'(RSAQ_CLK_MHZ * RSAQ_ED_UNIT_US);
  localparam int RSAQ_RAMP_NS = 4000;
  localparam logic [15:0] RSAQ_RAMP_CYC = 16'(RSAQ_RAMP_NS * RSAQ_CLK_MHZ / 1000);
  typedef enum logic [2:0] {
    RSAQ_ST_OFF, RSAQ_ST_TRANSMIT_PREPARE_STATE, RSAQ_ST_RX, RSAQ_ST_ACKWAIT, RSAQ_ST_TX, RSAQ_ST_RAMPDN
  } rsaq_state_t;
endpackage

// ===== rsaq_bb_model.sv
// baseband and i/q sample source model facing the radio sequencer
`timescale 1ns/1ps
module rsaq_bb_model (
  input wire logic pclk,
  input wire logic ack_tx_start,
  output logic preamble_det,
  output logic header_ok,
  output logic addr_match,
  output logic frame_done,
  output logic frame_abort,
  output logic fcs_ok,
  output logic ack_required,
  output logic tx_done,
  output logic iq_tx_start_flag,
  output logic iq_sample_clk
);
  int lat = 3;
  logic run = 1'b0;
  initial begin
    {frame_abort, frame_done, addr_match, header_ok, preamble_det} = '0;
    {fcs_ok, ack_required, tx_done, iq_tx_start_flag, iq_sample_clk} = '0;
    #3;
    // sample clock stands still outside bursts
    forever #80 iq_sample_clk = run ? ~iq_sample_clk : 1'b0;
  end
  // one-cycle event; qualifiers ride with frame_done
  task automatic ev(input logic [4:0] m, input logic ok, input logic ack);
    @(posedge pclk);
    {frame_abort, frame_done, addr_match, header_ok, preamble_det} <= m;
    fcs_ok <= ok;
    ack_required <= ack;
    @(posedge pclk);
    {frame_abort, frame_done, addr_match, header_ok, preamble_det} <= '0;
    fcs_ok <= 1'b0;
    ack_required <= 1'b0;
  endtask
  // ack frame leaves the air after lat cycles, slow or prompt
  always @(posedge pclk) begin
    if (ack_tx_start === 1'b1) begin
      repeat (lat) @(posedge pclk);
      tx_done <= 1'b1;
      @(posedge pclk);
      tx_done <= 1'b0;
    end
  end
  // zeros lead the flag, padding trails it through the down-ramp
  task automatic iq_flag(input logic v);
    run = 1'b1;
    repeat (4) @(posedge iq_sample_clk);
    iq_tx_start_flag <= v;
    if (!v) begin
      repeat (30) @(posedge iq_sample_clk);
      run = 1'b0;
    end
  endtask
endmodule // rsaq_bb_model

// ===== rsaq_radio_seq_tb_top.sv
// self-checking bench for the radio state sequencer
`timescale 1ns/1ps
module rsaq_radio_seq_tb_top;
  import rsaq_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [7:0] energy = '0;
  logic [31:0] prdata;
  logic pready, pslverr, agc_freeze, ack_tx_start, tx_active, iq_out_enable;
  logic iq_serial_out_clock, iq_rx_stream, preamble_det, header_ok, addr_match;
  logic frame_done, frame_abort, fcs_ok, ack_required, tx_done, iq_flag, iq_clk, b;
  logic [RSAQ_IRQ_W-1:0] irq_status;
  logic [7:0] dl;
  logic [31:0] expq[$];
  int errors = 0, checked = 0, cyc = 0, n;
  always #10 pclk = ~pclk;
  rsaq_radio_seq i_rsaq_radio_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .preamble_det(preamble_det), .header_ok(header_ok),
    .addr_match(addr_match), .frame_done(frame_done), .frame_abort(frame_abort),
    .fcs_ok(fcs_ok), .ack_required(ack_required), .energy_sample(energy),
    .iq_tx_start_flag(iq_flag), .iq_sample_clk(iq_clk), .agc_freeze(agc_freeze),
    .ack_tx_start(ack_tx_start), .tx_done(tx_done), .tx_active(tx_active),
    .iq_out_enable(iq_out_enable), .iq_serial_out_clock(iq_serial_out_clock),
    .iq_rx_stream(iq_rx_stream), .irq_status(irq_status));
  rsaq_bb_model i_rsaq_bb_model (.pclk(pclk), .ack_tx_start(ack_tx_start),
    .preamble_det(preamble_det), .header_ok(header_ok), .addr_match(addr_match),
    .frame_done(frame_done), .frame_abort(frame_abort), .fcs_ok(fcs_ok),
    .ack_required(ack_required), .tx_done(tx_done), .iq_tx_start_flag(iq_flag),
    .iq_sample_clk(iq_clk));
  task automatic summarize;
    $display("counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmpw(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmpb(input logic g, input logic e);
    cmpw({31'h0, e}, {31'h0, g});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq(input int i);
    n = 0;
    while (irq_status[i] !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    cmpb(irq_status[i], 1'b1);
  endtask
  // read data is taken at the completing edge only
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      cmpw(expq.pop_front(), prdata);
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      summarize;
    end
  end
  initial begin
    void'($urandom(21566));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(RSAQ_ADDR_CTRL, 32'hC0);
    rd(RSAQ_ADDR_EDD, 32'h10);
    wr(12'h100, $urandom);
    rd(12'h100, 32'h0);
    rd(RSAQ_ADDR_CTRL, 32'hC0);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_TX));
    rd(RSAQ_ADDR_STAT, 32'h0);
    cmpb(pslverr, 1'b0);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_TRANSMIT_PREPARE_STATE));
    wait_irq(RSAQ_IRQ_TRANSCEIVER_READY_IRQ);
    rd(RSAQ_ADDR_STAT, 32'h1);
    rd(RSAQ_ADDR_IRQ, 32'h10);
    $display("test reset and prepare done");
    energy <= 8'($urandom);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_RX));
    rd(RSAQ_ADDR_STAT, 32'h2);
    i_rsaq_bb_model.ev(5'h01, 1'b0, 1'b0);
    @(negedge pclk);
    cmpb(agc_freeze, 1'b1);
    i_rsaq_bb_model.ev(5'h02, 1'b0, 1'b0);
    i_rsaq_bb_model.ev(5'h04, 1'b0, 1'b0);
    i_rsaq_bb_model.ev(5'h10, 1'b0, 1'b0);
    repeat (2) @(negedge pclk);
    cmpb(agc_freeze, 1'b0);
    rd(RSAQ_ADDR_STAT, 32'h2);
    rd(RSAQ_ADDR_IRQ, 32'h05);
    i_rsaq_bb_model.ev(5'h08, 1'b0, 1'b0);
    rd(RSAQ_ADDR_STAT, 32'h2);
    rd(RSAQ_ADDR_IRQ, 32'h0);
    i_rsaq_bb_model.ev(5'h08, 1'b1, 1'b0);
    wait_irq(RSAQ_IRQ_FRAME_END_IRQ);
    rd(RSAQ_ADDR_STAT, 32'h1);
    rd(RSAQ_ADDR_IRQ, 32'h12);
    $display("test receive done");
    dl = 8'(1 + $urandom % 3);
    wr(RSAQ_ADDR_CTRL, 32'hC1);
    wr(RSAQ_ADDR_ACKL, {24'h0, dl});
    wr(RSAQ_ADDR_ACKH, 32'h0);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_RX));
    i_rsaq_bb_model.ev(5'h08, 1'b1, 1'b0);
    wait_irq(RSAQ_IRQ_FRAME_END_IRQ);
    rd(RSAQ_ADDR_STAT, 32'h1);
    rd(RSAQ_ADDR_IRQ, 32'h12);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_RX));
    i_rsaq_bb_model.lat = 60;
    i_rsaq_bb_model.ev(5'h08, 1'b1, 1'b1);
    n = 0;
    while (ack_tx_start !== 1'b1 && n < 1000) begin
      @(negedge pclk);
      n++;
    end
    cmpb(n >= int'(dl) * 50 - 2 && n <= (int'(dl) + 2) * 50, 1'b1);
    @(negedge pclk);
    cmpb(tx_active, 1'b1);
    wait_irq(RSAQ_IRQ_TRANSMIT_FRAME_END_IRQ);
    rd(RSAQ_ADDR_STAT, 32'h1);
    rd(RSAQ_ADDR_IRQ, 32'h1A);
    wr(RSAQ_ADDR_EDD, 32'h2);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_RX));
    wr(RSAQ_ADDR_CTRL, 32'h40);
    wait_irq(RSAQ_IRQ_EDC);
    rd(RSAQ_ADDR_IRQ, 32'h20);
    rd(RSAQ_ADDR_EDV, {24'h0, energy});
    wr(RSAQ_ADDR_CTRL, 32'h04);
    @(negedge pclk);
    cmpb(agc_freeze, 1'b1);
    wait_irq(RSAQ_IRQ_EDC);
    rd(RSAQ_ADDR_IRQ, 32'h20);
    rd(RSAQ_ADDR_EDV, {24'h0, energy});
    $display("test ack and energy done");
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_TRANSMIT_PREPARE_STATE));
    wait_irq(RSAQ_IRQ_TRANSCEIVER_READY_IRQ);
    rd(RSAQ_ADDR_IRQ, 32'h10);
    wr(RSAQ_ADDR_CTRL, 32'hD2);
    @(negedge pclk);
    cmpb(iq_out_enable, 1'b1);
    b = iq_serial_out_clock;
    repeat (4) @(negedge pclk);
    cmpb(iq_serial_out_clock, ~b);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_TX));
    rd(RSAQ_ADDR_STAT, 32'h1);
    i_rsaq_bb_model.iq_flag(1'b1);
    n = 0;
    while (tx_active !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    cmpb(tx_active, 1'b1);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_TRANSMIT_PREPARE_STATE));
    rd(RSAQ_ADDR_STAT, 32'h4);
    fork
      i_rsaq_bb_model.iq_flag(1'b0);
    join_none
    repeat (150) @(negedge pclk);
    cmpb(tx_active, 1'b1);
    rd(RSAQ_ADDR_STAT, 32'h5);
    wait_irq(RSAQ_IRQ_TRANSCEIVER_READY_IRQ);
    rd(RSAQ_ADDR_STAT, 32'h1);
    rd(RSAQ_ADDR_IRQ, 32'h10);
    wr(RSAQ_ADDR_CTRL, 32'hD0);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_TX));
    rd(RSAQ_ADDR_STAT, 32'h4);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_TRANSMIT_PREPARE_STATE));
    wait_irq(RSAQ_IRQ_TRANSCEIVER_READY_IRQ);
    rd(RSAQ_ADDR_STAT, 32'h1);
    rd(RSAQ_ADDR_IRQ, 32'h10);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_RX));
    @(negedge pclk);
    cmpb(iq_rx_stream, 1'b1);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_TRANSMIT_PREPARE_STATE));
    wait_irq(RSAQ_IRQ_TRANSCEIVER_READY_IRQ);
    cmpb(iq_rx_stream, 1'b0);
    wr(RSAQ_ADDR_CMD, 32'(RSAQ_CMD_OFF));
    rd(RSAQ_ADDR_STAT, 32'h0);
    $display("test iq mode done");
    summarize;
  end
endmodule // rsaq_radio_seq_tb_top
